// file: rtl/sfcd_regs.vh
`ifndef SFCD_REGS_VH
`define SFCD_REGS_VH
`define SFCD_OP_QENTER   8'h35
`define SFCD_OP_QEXIT    8'hf5
`define SFCD_OP_FREAD    8'h0b
`define SFCD_OP_DREAD    8'hbb
`define SFCD_OP_HBERASE  8'h52
`define SFCD_OP_SUSP0    8'h75
`define SFCD_OP_SUSP1    8'hb0
`define SFCD_OP_RESUME0  8'h7a
`define SFCD_OP_RESUME1  8'h30
`define SFCD_OP_SIG      8'hab
`define SFCD_OP_MAKER    8'h90
`define SFCD_OP_FSTAT    8'h44
`define SFCD_OP_CFGRD    8'h15
`define SFCD_OP_OTPIN    8'hb1
`define SFCD_OP_OTPOUT   8'hc1
`define SFCD_OP_LOCKWR   8'h2c
`define SFCD_OP_PPROG    8'he3
`define SFCD_OP_PCLEAR   8'he4
`define SFCD_OP_FARM     8'h41
`define SFCD_OP_SECWR    8'h2f
`define SFCD_OP_SECRD    8'h2b
`define SFCD_OP_RSTARM   8'h66
`define SFCD_OP_RST      8'h99
`define SFCD_CFG_DC_LO   6
`define SFCD_CFG_DC_HI   7
`define SFCD_CFG_RST     8'h00
`define SFCD_SIG_DUMMY   8'h18
`define SFCD_MAKER_DUMMY 8'h10
`define SFCD_BITS_SPI    4'h8
`define SFCD_BITS_QPI    4'h2
`define SFCD_BITS_DIO    4'h4
`endif

// file: rtl/sfcd_sync.v
`timescale 1ns/1ns
module sfcd_sync (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rstSync_n,
    // Async pins in, synced out
    input  wire [5:0] pinIn,
    output wire [5:0] pinOut
);
    reg [5:0] stage1_r;
    reg [5:0] stage2_r;
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1_r <= 6'h3f;
            stage2_r <= 6'h3f;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
        end
    end
    assign pinOut = stage2_r;
endmodule // sfcd_sync

// file: rtl/sfcd_decoder.v
`timescale 1ns/1ns
`include "sfcd_regs.vh"
module sfcd_decoder (
    // System
    input  wire       clk_sys,
    input  wire       rst_n,
    // Serial link
    input  wire       sclk,
    input  wire       csLink_n,
    input  wire [3:0] sioIn,
    output reg  [3:0] sioOut,
    output reg  [3:0] sioOe,
    // Device state
    input  wire [7:0] cfgReg,
    input  wire [7:0] factoryStat,
    output reg        quadMode,
    output reg        otpMode,
    output reg        factoryArmed,
    // One-cycle command pulses, held address and data
    output reg        cmdWake,
    output reg        cmdSuspend,
    output reg        cmdResume,
    output reg        cmdErase,
    output reg        cmdLockWr,
    output reg        cmdProtProg,
    output reg        cmdProtClear,
    output reg        cmdSecWr,
    output reg        cmdSoftReset,
    output reg [31:0] cmdAddr,
    output reg [7:0]  cmdData
);
    parameter [7:0] MAKER_CODE = 8'h5a;   // Arbitrary value
    parameter [7:0] PART_CODE  = 8'h17;   // Arbitrary value
    parameter [7:0] SIG_CODE   = 8'h17;   // Arbitrary value

    // ----------------------------------------
    // Reset release and pin sync
    // ----------------------------------------
    reg  [1:0] rstPipe_r;
    wire       rstSync_n = rstPipe_r[1];
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rstPipe_r <= 2'h0;
        else
            rstPipe_r <= {rstPipe_r[0], 1'b1};
    end

    wire [5:0] pinSync;
    sfcd_sync uSync (
        .clk_sys   (clk_sys),
        .rstSync_n (rstSync_n),
        .pinIn     ({sclk, csLink_n, sioIn}),
        .pinOut    (pinSync)
    );
    wire       sclkS = pinSync[5];
    wire       csS_n = pinSync[4];
    wire [3:0] sioS  = pinSync[3:0];

    reg  sclkD_r;
    reg  csD_r;
    wire sclkRise = sclkS & ~sclkD_r;
    wire sclkFall = ~sclkS & sclkD_r;
    wire csRise   = csS_n & ~csD_r;
    wire csFall   = ~csS_n & csD_r;

    // ----------------------------------------
    // Frame state
    // ----------------------------------------
    localparam [5:0] ST_OP    = 6'h01;
    localparam [5:0] ST_ADDR  = 6'h02;
    localparam [5:0] ST_DUMMY = 6'h04;
    localparam [5:0] ST_DIN   = 6'h08;
    localparam [5:0] ST_DOUT  = 6'h10;
    localparam [5:0] ST_IGN   = 6'h20;

    reg [5:0]  state_r;
    reg [7:0]  opcode_r;
    reg [7:0]  shift_r;
    reg [3:0]  bitCnt_r;
    reg [2:0]  addrLeft_r;
    reg [7:0]  dummyLeft_r;
    reg [7:0]  outByte_r;
    reg [2:0]  outCnt_r;
    reg        idSel_r;
    reg        boundary_r;
    reg        rstArmed_r;
    reg        prevArm_r;
    reg        dualAddr_r;

    // Beats per byte: single line 8, dual 4, quad 2
    wire       dualBeat    = dualAddr_r && state_r != ST_OP;
    wire [3:0] bitsPerByte = quadMode ? `SFCD_BITS_QPI :
                             dualBeat ? `SFCD_BITS_DIO : `SFCD_BITS_SPI;
    wire [7:0] shiftNxt    = quadMode ? {shift_r[3:0], sioS} :
                             dualBeat ? {shift_r[5:0], sioS[1:0]} :
                             {shift_r[6:0], sioS[0]};
    wire       byteDone    = (bitCnt_r == bitsPerByte - 4'h1);
    wire [1:0] dcSel       = {cfgReg[`SFCD_CFG_DC_HI], cfgReg[`SFCD_CFG_DC_LO]};

    // Fast read dummy count from config
    function [7:0] fastDummy;
        input [1:0] sel;
        input       dual;
        begin
            case (sel)
                2'h0:    fastDummy = dual ? 8'h04 : 8'h08;
                2'h1:    fastDummy = 8'h06;
                2'h2:    fastDummy = 8'h08;
                default: fastDummy = 8'h0a;
            endcase
        end
    endfunction

    // Opcode legal in current mode
    function legalOp;
        input [7:0] op;
        input       quad;
        begin
            case (op)
                `SFCD_OP_QENTER, `SFCD_OP_DREAD, `SFCD_OP_LOCKWR,
                `SFCD_OP_PPROG, `SFCD_OP_PCLEAR:
                    legalOp = ~quad;
                `SFCD_OP_QEXIT:
                    legalOp = quad;
                `SFCD_OP_FREAD, `SFCD_OP_HBERASE, `SFCD_OP_SUSP0, `SFCD_OP_SUSP1,
                `SFCD_OP_RESUME0, `SFCD_OP_RESUME1, `SFCD_OP_SIG, `SFCD_OP_MAKER,
                `SFCD_OP_FSTAT, `SFCD_OP_CFGRD, `SFCD_OP_OTPIN, `SFCD_OP_OTPOUT,
                `SFCD_OP_FARM, `SFCD_OP_SECWR, `SFCD_OP_SECRD, `SFCD_OP_RSTARM,
                `SFCD_OP_RST:
                    legalOp = 1'b1;
                default:
                    legalOp = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Main sequencer
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sclkD_r      <= 1'b1;
            csD_r        <= 1'b1;
            state_r      <= ST_OP;
            opcode_r     <= 8'h00;
            shift_r      <= 8'h00;
            bitCnt_r     <= 4'h0;
            addrLeft_r   <= 3'h0;
            dummyLeft_r  <= 8'h00;
            outByte_r    <= 8'h00;
            outCnt_r     <= 3'h0;
            idSel_r      <= 1'b0;
            boundary_r   <= 1'b0;
            rstArmed_r   <= 1'b0;
            prevArm_r    <= 1'b0;
            dualAddr_r   <= 1'b0;
            sioOut       <= 4'h0;
            sioOe        <= 4'h0;
            quadMode     <= 1'b0;
            otpMode      <= 1'b0;
            factoryArmed <= 1'b0;
            cmdWake      <= 1'b0;
            cmdSuspend   <= 1'b0;
            cmdResume    <= 1'b0;
            cmdErase     <= 1'b0;
            cmdLockWr    <= 1'b0;
            cmdProtProg  <= 1'b0;
            cmdProtClear <= 1'b0;
            cmdSecWr     <= 1'b0;
            cmdSoftReset <= 1'b0;
            cmdAddr      <= 32'h0;
            cmdData      <= 8'h00;
        end else begin
            sclkD_r      <= sclkS;
            csD_r        <= csS_n;
            cmdWake      <= 1'b0;
            cmdSuspend   <= 1'b0;
            cmdResume    <= 1'b0;
            cmdErase     <= 1'b0;
            cmdLockWr    <= 1'b0;
            cmdProtProg  <= 1'b0;
            cmdProtClear <= 1'b0;
            cmdSecWr     <= 1'b0;
            cmdSoftReset <= 1'b0;
            if (csFall || csS_n) begin
                state_r    <= ST_OP;
                bitCnt_r   <= 4'h0;
                boundary_r <= 1'b0;
                sioOe      <= 4'h0;
            end
            // Commands execute only at frame end on a byte edge
            if (csRise && boundary_r && state_r != ST_IGN) begin
                prevArm_r <= 1'b0;
                case (opcode_r)
                    `SFCD_OP_QENTER:  quadMode <= 1'b1;
                    `SFCD_OP_QEXIT:   quadMode <= 1'b0;
                    `SFCD_OP_HBERASE: if (addrLeft_r == 3'h0 && state_r == ST_OP)
                                          cmdErase <= 1'b1;
                    `SFCD_OP_SUSP0, `SFCD_OP_SUSP1:
                        cmdSuspend <= 1'b1;
                    `SFCD_OP_RESUME0, `SFCD_OP_RESUME1:
                        cmdResume <= 1'b1;
                    `SFCD_OP_SIG:     if (state_r == ST_DUMMY &&
                                          dummyLeft_r == `SFCD_SIG_DUMMY)
                                          cmdWake <= 1'b1;
                    `SFCD_OP_OTPIN:   otpMode <= 1'b1;
                    `SFCD_OP_OTPOUT:  otpMode <= 1'b0;
                    `SFCD_OP_LOCKWR:  if (state_r == ST_OP)
                                          cmdLockWr <= 1'b1;
                    `SFCD_OP_PPROG:   if (addrLeft_r == 3'h0 && state_r == ST_OP)
                                          cmdProtProg <= 1'b1;
                    `SFCD_OP_PCLEAR:  cmdProtClear <= 1'b1;
                    `SFCD_OP_FARM:    factoryArmed <= 1'b1;
                    `SFCD_OP_SECWR:   cmdSecWr <= 1'b1;
                    `SFCD_OP_RSTARM:  prevArm_r <= 1'b1;
                    `SFCD_OP_RST:     if (prevArm_r) begin
                                          cmdSoftReset <= 1'b1;
                                          quadMode     <= 1'b0;
                                          otpMode      <= 1'b0;
                                          factoryArmed <= 1'b0;
                                      end
                    default:          ;
                endcase
                if (opcode_r == `SFCD_OP_HBERASE && addrLeft_r == 3'h0)
                    factoryArmed <= 1'b0;
            end else if (csRise) begin
                prevArm_r <= 1'b0;
            end
            if (!csS_n && sclkRise) begin
                shift_r    <= shiftNxt;
                bitCnt_r   <= byteDone ? 4'h0 : bitCnt_r + 4'h1;
                boundary_r <= byteDone;
                case (state_r)
                    ST_OP: if (byteDone && bitCnt_r != 4'hf) begin
                        opcode_r <= shiftNxt;
                        if (!legalOp(shiftNxt, quadMode)) begin
                            state_r <= ST_IGN;
                        end else begin
                            addrLeft_r  <= 3'h0;
                            dummyLeft_r <= 8'h00;
                            dualAddr_r  <= 1'b0;
                            case (shiftNxt)
                                `SFCD_OP_FREAD: begin
                                    state_r     <= ST_ADDR;
                                    addrLeft_r  <= 3'h3;
                                    dummyLeft_r <= fastDummy(dcSel, 1'b0);
                                end
                                `SFCD_OP_DREAD: begin
                                    state_r     <= ST_ADDR;
                                    addrLeft_r  <= 3'h3;
                                    dualAddr_r  <= 1'b1;
                                    dummyLeft_r <= fastDummy(dcSel, 1'b1);
                                end
                                `SFCD_OP_HBERASE: begin
                                    state_r    <= ST_ADDR;
                                    addrLeft_r <= 3'h3;
                                end
                                `SFCD_OP_PPROG: begin
                                    state_r    <= ST_ADDR;
                                    addrLeft_r <= 3'h4;
                                end
                                `SFCD_OP_SIG: begin
                                    state_r     <= ST_DUMMY;
                                    dummyLeft_r <= `SFCD_SIG_DUMMY;
                                end
                                `SFCD_OP_MAKER: begin
                                    state_r    <= ST_ADDR;
                                    addrLeft_r <= 3'h3;
                                end
                                `SFCD_OP_FSTAT: begin
                                    state_r   <= ST_DOUT;
                                    outByte_r <= factoryStat;
                                    outCnt_r  <= 3'h0;
                                end
                                `SFCD_OP_CFGRD: begin
                                    state_r   <= ST_DOUT;
                                    outByte_r <= cfgReg;
                                    outCnt_r  <= 3'h0;
                                end
                                `SFCD_OP_LOCKWR: state_r <= ST_DIN;
                                default: state_r <= ST_OP;
                            endcase
                            if (shiftNxt != `SFCD_OP_HBERASE &&
                                shiftNxt != `SFCD_OP_PPROG &&
                                shiftNxt != `SFCD_OP_LOCKWR &&
                                shiftNxt != `SFCD_OP_FREAD &&
                                shiftNxt != `SFCD_OP_DREAD &&
                                shiftNxt != `SFCD_OP_SIG &&
                                shiftNxt != `SFCD_OP_MAKER &&
                                shiftNxt != `SFCD_OP_FSTAT &&
                                shiftNxt != `SFCD_OP_CFGRD)
                                bitCnt_r <= 4'hf;                  // Extra clocks void
                        end
                    end else if (bitCnt_r == 4'hf) begin
                        bitCnt_r   <= 4'hf;
                        boundary_r <= 1'b0;
                    end
                    ST_ADDR: if (byteDone) begin
                        if (opcode_r != `SFCD_OP_MAKER)
                            cmdAddr <= {cmdAddr[23:0], shiftNxt};
                        addrLeft_r <= addrLeft_r - 3'h1;
                        if (addrLeft_r == 3'h1)
                            state_r <= (dummyLeft_r != 8'h00) ? ST_DUMMY : ST_OP;
                        if (addrLeft_r == 3'h1 && opcode_r == `SFCD_OP_MAKER) begin
                            state_r   <= ST_DOUT;
                            idSel_r   <= shiftNxt[0];
                            outCnt_r  <= 3'h0;
                            outByte_r <= shiftNxt[0] ? PART_CODE : MAKER_CODE;
                        end
                    end
                    ST_DUMMY: begin
                        // Dummy counts clock beats, not bytes
                        bitCnt_r    <= 4'h0;
                        dummyLeft_r <= dummyLeft_r - 8'h01;
                        if (dummyLeft_r == 8'h01) begin
                            state_r  <= ST_DOUT;
                            outCnt_r <= 3'h0;
                            case (opcode_r)
                                `SFCD_OP_SIG:   outByte_r <= SIG_CODE;
                                default:        outByte_r <= 8'h00;
                            endcase
                        end
                    end
                    ST_DIN: if (byteDone) begin
                        cmdData <= shiftNxt;
                        state_r <= ST_OP;
                    end
                    default: ;
                endcase
            end
            // Output shifts on falling edge
            if (!csS_n && sclkFall && state_r == ST_DOUT) begin
                sioOe <= quadMode ? 4'hf : (dualAddr_r ? 4'h3 : 4'h2);
                if (quadMode) begin
                    sioOut   <= outByte_r[7:4];
                    outByte_r <= {outByte_r[3:0], 4'h0};
                end else if (dualAddr_r) begin
                    sioOut    <= {2'h0, outByte_r[7:6]};
                    outByte_r <= {outByte_r[5:0], 2'h0};
                end else begin
                    sioOut   <= {2'h0, outByte_r[7], 1'b0};
                    outByte_r <= {outByte_r[6:0], 1'b0};
                end
                outCnt_r <= outCnt_r + 3'h1;
                if ((quadMode && outCnt_r[0]) || (dualAddr_r && outCnt_r[1:0] == 2'h3) ||
                    (!quadMode && !dualAddr_r && outCnt_r == 3'h7)) begin
                    outCnt_r <= 3'h0;
                    idSel_r  <= ~idSel_r;
                    case (opcode_r)
                        `SFCD_OP_MAKER: outByte_r <= idSel_r ? MAKER_CODE : PART_CODE;
                        `SFCD_OP_SIG:   outByte_r <= SIG_CODE;
                        `SFCD_OP_FSTAT: outByte_r <= factoryStat;
                        `SFCD_OP_CFGRD: outByte_r <= cfgReg;
                        default:        outByte_r <= 8'h00;
                    endcase
                end
            end
        end
    end
endmodule // sfcd_decoder

// file: bench/sfcd_dec_props.sv
`timescale 1ns/1ns
module sfcd_dec_props (
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Link
    input wire       csLink_n,
    input wire [3:0] sioOe,
    // State and pulses
    input wire       quadMode,
    input wire       otpMode,
    input wire       factoryArmed,
    input wire       cmdWake,
    input wire       cmdSuspend,
    input wire       cmdResume,
    input wire       cmdErase,
    input wire       cmdLockWr,
    input wire       cmdProtProg,
    input wire       cmdProtClear,
    input wire       cmdSecWr,
    input wire       cmdSoftReset
);
    wire [8:0] pulses = {cmdWake, cmdSuspend, cmdResume, cmdErase, cmdLockWr,
                         cmdProtProg, cmdProtClear, cmdSecWr, cmdSoftReset};
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Commands act only once the frame is closed
    pulse_after_cs_a: assert property (|pulses |-> csLink_n && $past(csLink_n, 2))
        else $error("command pulse while selected");
    pulse_single_a: assert property (|pulses |=> !(|pulses))
        else $error("command pulse longer than one cycle");
    pulse_onehot_a: assert property ($onehot0(pulses))
        else $error("two command pulses at once");
    oe_idle_a: assert property (csLink_n [*6] |-> sioOe == 4'h0)
        else $error("output driven while deselected");
    single_lines_a: assert property (!quadMode |-> sioOe[3:2] == 2'b00)
        else $error("upper lines driven in single mode");
    mode_at_cs_a: assert property ($changed({quadMode, otpMode, factoryArmed}) |->
        $past(csLink_n, 2))
        else $error("mode changed inside a frame");
    rst_quiet_a: assert property ($rose(rst_n) |-> !quadMode && !otpMode && sioOe == 4'h0)
        else $error("not idle after reset");
    oe_late_a: assert property (!quadMode && $rose(|sioOe) |-> !$past(csLink_n, 60))
        else $error("output before a full opcode");
endmodule // sfcd_dec_props

// file: bench/sfcd_host_model.sv
`timescale 1ns/1ns
module sfcd_host_model (
    // Clock
    input  wire       clk_sys,
    // Host-driven lines
    output reg        sclk,
    output reg        csLink_n,
    output reg  [3:0] sioDrv,
    // Resolved data lines
    input  wire [3:0] sioLine
);
    parameter DESEL_CYC = 24;  // Min deselect time in clk_sys cycles
    reg [7:0] rxByte;
    initial begin
        sclk     = 1'b0;
        csLink_n = 1'b1;
        sioDrv   = 4'h0;
        rxByte   = 8'h00;
    end
    // Sampled just before the fall: output from the previous fall has long settled
    task beat(input [3:0] v, input quad);
        begin
            sioDrv <= v;
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            rxByte = quad ? {rxByte[3:0], sioLine} : {rxByte[6:0], sioLine[1]};
            sclk <= 1'b0;
        end
    endtask
    task xfer(input [7:0] b, input quad);
        integer i;
        begin
            if (quad) begin
                beat(b[7:4], 1'b1);
                beat(b[3:0], 1'b1);
            end else begin
                for (i = 7; i >= 0; i = i - 1)
                    beat({3'h0, b[i]}, 1'b0);
            end
        end
    endtask
    task open;
        begin
            csLink_n <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    // Released lines show the inverse, never the stale value
    task shut;
        begin
            repeat (4) @(posedge clk_sys);
            csLink_n <= 1'b1;
            sioDrv   <= ~sioDrv;
            repeat (DESEL_CYC) @(posedge clk_sys);
        end
    endtask
endmodule // sfcd_host_model

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam [7:0] MAKER = 8'h3c;  // Arbitrary value
    localparam [7:0] PART  = 8'h81;  // Arbitrary value
    localparam [7:0] SIG   = 8'h6e;  // Arbitrary value
    reg         clk_sys, rst_n, csPrev, qm;
    reg  [7:0]  cfgReg, factoryStat;
    reg  [9:0]  seen;
    wire        sclk, csLink_n, quadMode, otpMode, factoryArmed;
    wire        cmdWake, cmdSuspend, cmdResume, cmdErase, cmdLockWr;
    wire        cmdProtProg, cmdProtClear, cmdSecWr, cmdSoftReset;
    wire [3:0]  sioDrv, sioOut, sioOe, sioLine;
    wire [31:0] cmdAddr;
    wire [7:0]  cmdData;
    integer     fail_count, n_compared, k, p;
    assign sioLine = (sioOe & sioOut) | (~sioOe & sioDrv);
    sfcd_decoder #(.MAKER_CODE(MAKER), .PART_CODE(PART), .SIG_CODE(SIG)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .csLink_n(csLink_n),
        .sioIn(sioLine), .sioOut(sioOut), .sioOe(sioOe), .cfgReg(cfgReg),
        .factoryStat(factoryStat), .quadMode(quadMode), .otpMode(otpMode),
        .factoryArmed(factoryArmed), .cmdWake(cmdWake), .cmdSuspend(cmdSuspend),
        .cmdResume(cmdResume), .cmdErase(cmdErase), .cmdLockWr(cmdLockWr),
        .cmdProtProg(cmdProtProg), .cmdProtClear(cmdProtClear), .cmdSecWr(cmdSecWr),
        .cmdSoftReset(cmdSoftReset), .cmdAddr(cmdAddr), .cmdData(cmdData));
    sfcd_host_model host (.clk_sys(clk_sys), .sclk(sclk), .csLink_n(csLink_n),
        .sioDrv(sioDrv), .sioLine(sioLine));
    // Sticky per-frame record: bit 9 any drive, bits 8:0 pulses
    always @(posedge clk_sys) begin
        csPrev <= csLink_n;
        if (csPrev && !csLink_n)
            seen <= 10'h000;
        else
            seen <= seen | {|sioOe, cmdWake, cmdSuspend, cmdResume, cmdErase, cmdLockWr,
                            cmdProtProg, cmdProtClear, cmdSecWr, cmdSoftReset};
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task send(input [7:0] op, input integer n, input [31:0] d);
        integer i;
        begin
            host.open();
            host.xfer(op, qm);
            for (i = n - 1; i >= 0; i = i - 1)
                host.xfer(d[8*i +: 8], qm);
            host.shut();
        end
    endtask
    task rdSeq(input [7:0] op, input integer nPre, input [7:0] lastPre,
               input integer nData, input [15:0] exp);
        integer    i;
        reg [15:0] got;
        begin
            host.open();
            host.xfer(op, qm);
            for (i = 1; i <= nPre; i = i + 1)
                host.xfer((i == nPre) ? lastPre : 8'h00, qm);
            got = 16'h0000;
            for (i = 0; i < nData; i = i + 1) begin
                host.xfer(8'hff, qm);
                got = {got[7:0], host.rxByte};
            end
            host.shut();
            check(got, exp);
            check(seen[9], 1'b1);
        end
    endtask
    // Opcode, single-only flag, OTP level, expected pulse
    function [19:0] opRow(input integer i);
        case (i)
            0: opRow = 20'h75080;
            1: opRow = 20'hb0080;
            2: opRow = 20'h7a040;
            3: opRow = 20'h30040;
            4: opRow = 20'hab100;
            5: opRow = 20'he4804;
            6: opRow = 20'h2f002;
            7: opRow = 20'h2b000;
            8: opRow = 20'hb1200;
            default: opRow = 20'hc1000;
        endcase
    endfunction
    task t_mode;
        begin
            send(8'h35, 0, 0);
            qm = 1'b1;
            check(quadMode, 1'b1);
            send(8'h35, 0, 0);
            check({quadMode, seen}, 11'h400);
            send(8'h2c, 1, 32'h5a);
            check(seen, 10'h000);
            rdSeq(8'h15, 0, 8'h00, 1, 16'h0025);
            rdSeq(8'h44, 0, 8'h00, 1, 16'h009e);
            rdSeq(8'h0b, 7, 8'h00, 1, 16'h0000);
            cfgReg <= 8'hc0;
            rdSeq(8'h0b, 8, 8'h00, 1, 16'h0000);
            cfgReg <= 8'h25;
            send(8'hf5, 0, 0);
            qm = 1'b0;
            check(quadMode, 1'b0);
            send(8'hf5, 0, 0);
            check({quadMode, seen}, 11'h000);
            $display("t_mode done");
        end
    endtask
    task t_reads;
        begin
            rdSeq(8'h15, 0, 8'h00, 1, 16'h0025);
            rdSeq(8'hab, 3, 8'h00, 1, {8'h00, SIG});
            rdSeq(8'h90, 3, 8'h00, 2, {MAKER, PART});
            rdSeq(8'h90, 3, 8'h01, 2, {PART, MAKER});
            rdSeq(8'h0b, 4, 8'h00, 1, 16'h0000);
            $display("t_reads done");
        end
    endtask
    task t_dual;
        integer    i;
        reg [23:0] a;
        reg [7:0]  got;
        begin
            a = 24'h5a3c96;
            got = 8'h00;
            host.open();
            host.xfer(8'hbb, 1'b0);
            for (i = 11; i >= 0; i = i - 1)
                host.beat({2'h0, a[2*i +: 2]}, 1'b1);
            for (i = 0; i < 8; i = i + 1) begin
                host.beat(4'hf, 1'b1);
                got = (i < 4) ? got : {got[5:0], host.rxByte[1:0]};
            end
            host.shut();
            check({seen[9], got, cmdAddr[23:0]}, {1'b1, 8'h00, a});
            $display("t_dual done");
        end
    endtask
    task t_table;
        reg [19:0] row;
        begin
            for (p = 0; p < 2; p = p + 1) begin
                for (k = 0; k < 10; k = k + 1) begin
                    row = opRow(k);
                    send(row[19:12], 0, 0);
                    check({otpMode, seen}, {row[9], 1'b0, (qm && row[11]) ? 9'h000 : row[8:0]});
                end
                send(qm ? 8'hf5 : 8'h35, 0, 0);
                qm = ~qm;
            end
            $display("t_table done");
        end
    endtask
    task t_addr;
        begin
            send(8'h52, 3, 32'h123456);
            check({seen, cmdAddr[23:0]}, {10'h020, 24'h123456});
            send(8'he3, 4, 32'ha1b2c3d4);
            check({seen, cmdAddr}, {10'h008, 32'ha1b2c3d4});
            send(8'h2c, 1, 32'h5a);
            check({seen, cmdData}, {10'h010, 8'h5a});
            host.open();
            host.xfer(8'h75, 1'b0);
            host.beat(4'h0, 1'b0);
            host.shut();
            check(seen, 10'h000);
            send(8'h66, 0, 0);
            send(8'h99, 0, 0);
            check(seen, 10'h001);
            send(8'h66, 0, 0);
            send(8'h2b, 0, 0);
            send(8'h99, 0, 0);
            check(seen, 10'h000);
            send(8'h41, 0, 0);
            check(factoryArmed, 1'b1);
            $display("t_addr done");
        end
    endtask
    task close_out;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n       = 1'b0;
        cfgReg      = 8'h25;
        factoryStat = 8'h9e;
        fail_count  = 0;
        n_compared  = 0;
        qm          = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_mode;
        t_reads;
        t_dual;
        t_table;
        t_addr;
        close_out;
    end
    // Hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        $display("BAD %0t watchdog expired", $time);
        fail_count = fail_count + 1;
        close_out;
    end
endmodule // testbench
bind sfcd_decoder sfcd_dec_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .csLink_n(csLink_n), .sioOe(sioOe), .quadMode(quadMode), .otpMode(otpMode),
    .factoryArmed(factoryArmed), .cmdWake(cmdWake), .cmdSuspend(cmdSuspend),
    .cmdResume(cmdResume), .cmdErase(cmdErase), .cmdLockWr(cmdLockWr),
    .cmdProtProg(cmdProtProg), .cmdProtClear(cmdProtClear), .cmdSecWr(cmdSecWr),
    .cmdSoftReset(cmdSoftReset));
